// File: inc/rcf_pkg.sv
// package for the reset cause flag block: register map, field positions,
// reset values and small helper functions.
// assumes a 16-bit register port with word index addressing.
package rcf_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // register indices
  localparam logic [3:0] ADDR_CAUSE     = 4'h0;  // reset_cause_control
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK  = 4'h2;
  localparam logic [3:0] ADDR_WDT_STATE = 4'h3;

  // field positions in reset_cause_control
  localparam int unsigned BIT_TRAP  = 15;
  localparam int unsigned BIT_ILLOP = 14;
  localparam int unsigned BIT_CFGMM = 9;
  localparam int unsigned BIT_EXT   = 7;
  localparam int unsigned BIT_SWRST = 6;
  localparam int unsigned BIT_SWDT  = 5;
  localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG  = 4;

  // writable bits of reset_cause_control; the rest read as zero
  localparam logic [15:0] CAUSE_WMASK = 16'hC2F0;
  // the cause flags alone, without the watchdog enable
  localparam logic [15:0] FLAG_MASK   = 16'hC2D0;
  localparam logic [15:0] CAUSE_RST   = 16'h0000;
  localparam logic [15:0] MASK_RST    = 16'h0000;

  // interrupt register width and reset value
  localparam int unsigned IRQ_W    = 6;
  localparam logic [5:0]  IRQ_RST  = 6'h00;

  // gather the six cause flags into one compact vector
  function automatic logic [5:0] pack_flags(input logic [15:0] v);
    pack_flags = {v[BIT_TRAP], v[BIT_ILLOP], v[BIT_CFGMM],
                  v[BIT_EXT], v[BIT_SWRST], v[BIT_WATCHDOG_TIMEOUT_FLAG]};
  endfunction

  // scatter a compact vector back into register positions
  function automatic logic [15:0] unpack_flags(input logic [5:0] f);
    logic [15:0] v;
    v = 16'h0000;
    v[BIT_TRAP]  = f[5];
    v[BIT_ILLOP] = f[4];
    v[BIT_CFGMM] = f[3];
    v[BIT_EXT]   = f[2];
    v[BIT_SWRST] = f[1];
    v[BIT_WATCHDOG_TIMEOUT_FLAG]  = f[0];
    unpack_flags = v;
  endfunction

endpackage

// File: logic/rcf_sticky.sv
// sticky event register: hardware set, write-one-to-clear.
// assumes set and clear arrive as one-cycle vectors on clk_i.
`timescale 1ns/100ps
module rcf_sticky #(
  parameter int unsigned W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] next_q;

  // set beats clear so an event in the clearing cycle is kept
  assign next_q = (q_o & ~clr_i) | set_i;

  // plain synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      q_o <= next_q;
    end
  end

endmodule

// File: logic/rcf_top.sv
// reset cause flags and watchdog enable control, with event interrupt.
// assumes the reset sources give one-cycle pulses on clk_i, and that
// rst_i is the power-on reset only; cause resets do not clear this block.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
module rcf_top
  import rcf_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              master_clear_pin_i,
  input  wire logic              sw_reset_instr_i,
  input  wire logic              watchdog_expired_i,
  input  wire logic              trap_conflict_i,
  input  wire logic              illegal_op_i,
  input  wire logic              config_mismatch_i,
  input  wire logic              cfg_watchdog_force_on_i,
  output logic                   watchdog_enable_o,
  output logic                   irq_o
);

  // cause events gathered in the compact flag order
  logic [5:0]  evt;
  logic [15:0] cause;
  logic [5:0]  irq_stat;
  logic [5:0]  irq_mask;
  logic [15:0] next_cause;
  logic        wr_cause;
  logic        wr_stat;
  logic        wr_mask;
  logic [15:0] rd_mux;
  logic [15:0] evt_bits;
  logic        sw_wdt;

  assign evt = {trap_conflict_i, illegal_op_i, config_mismatch_i,
                master_clear_pin_i, sw_reset_instr_i,
                watchdog_expired_i};
  assign evt_bits = unpack_flags(evt);
  assign sw_wdt   = cause[BIT_SWDT];

  // address decode
  assign wr_cause = wr_i && (addr_i == ADDR_CAUSE);
  assign wr_stat  = wr_i && (addr_i == ADDR_IRQ_STAT);
  assign wr_mask  = wr_i && (addr_i == ADDR_IRQ_MASK);

  // software write replaces flags; hardware events still win over it
  // so a cause arriving with a clearing write is never lost
  assign next_cause = (wr_cause ? (wdata_i & CAUSE_WMASK) : cause)
                      | evt_bits;

  // cause register; only power-on reset clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause <= CAUSE_RST;
    end else begin
      cause <= next_cause;
    end
  end

  // interrupt status: hardware set, write one to clear
  rcf_sticky #(
    .W (IRQ_W)
  ) u_stat (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .set_i (evt),
    .clr_i (wr_stat ? wdata_i[5:0] : 6'h00),
    .q_o   (irq_stat)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= IRQ_RST;
    end else if (wr_mask) begin
      irq_mask <= wdata_i[5:0];
    end
  end

  // software enable unless the configuration forces it on
  assign watchdog_enable_o = cfg_watchdog_force_on_i | sw_wdt;
  assign irq_o = |(irq_stat & irq_mask);

  // read select; unmapped indices read zero
  always_comb begin
    case (addr_i)
      ADDR_CAUSE:     rd_mux = cause;
      ADDR_IRQ_STAT:  rd_mux = {10'h000, irq_stat};
      ADDR_IRQ_MASK:  rd_mux = {10'h000, irq_mask};
      ADDR_WDT_STATE: rd_mux = {15'h0000, watchdog_enable_o};
      default:        rd_mux = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  // checks
  property p_ext_set;
    @(posedge clk_i) disable iff (rst_i)
    master_clear_pin_i |=> cause[BIT_EXT];
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("ext pin flag not set");

  property p_swr_set;
    @(posedge clk_i) disable iff (rst_i)
    sw_reset_instr_i |=> cause[BIT_SWRST];
  endproperty
  a_swr_set: assert property (p_swr_set)
    else $error("sw reset flag not set");

  property p_swdt_wr;
    @(posedge clk_i) disable iff (rst_i)
    wr_cause |=> (sw_wdt == $past(wdata_i[BIT_SWDT]));
  endproperty
  a_swdt_wr: assert property (p_swdt_wr)
    else $error("watchdog enable not written");

  property p_force_on;
    @(posedge clk_i) disable iff (rst_i)
    cfg_watchdog_force_on_i |-> watchdog_enable_o;
  endproperty
  a_force_on: assert property (p_force_on)
    else $error("watchdog not forced on");

  property p_watchdog_timeout_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    watchdog_expired_i |=> cause[BIT_WATCHDOG_TIMEOUT_FLAG];
  endproperty
  a_watchdog_timeout_flag_set: assert property (p_watchdog_timeout_flag_set)
    else $error("time-out flag not set");

  property p_sw_write;
    @(posedge clk_i) disable iff (rst_i)
    (wr_cause && evt == 6'h00) |=>
      ((cause & FLAG_MASK) == ($past(wdata_i) & FLAG_MASK));
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("flag write not taken");

  property p_trap_set;
    @(posedge clk_i) disable iff (rst_i)
    trap_conflict_i |=> cause[BIT_TRAP];
  endproperty
  a_trap_set: assert property (p_trap_set)
    else $error("trap flag not set");

  property p_illop_set;
    @(posedge clk_i) disable iff (rst_i)
    illegal_op_i |=> cause[BIT_ILLOP];
  endproperty
  a_illop_set: assert property (p_illop_set)
    else $error("illegal op flag not set");

  property p_cfgmm_set;
    @(posedge clk_i) disable iff (rst_i)
    config_mismatch_i |=> cause[BIT_CFGMM];
  endproperty
  a_cfgmm_set: assert property (p_cfgmm_set)
    else $error("mismatch flag not set");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    !wr_cause |=> ((cause & $past(cause)) == $past(cause));
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag lost without software clear");

  // read data must drop back to zero when no read was taken
  property p_rdata_idle;
    @(posedge clk_i) disable iff (rst_i)
    !rd_i |=> (rdata_o == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data held past its cycle");

  // a cause read returns the register as it stood at the strobe
  property p_rd_cause;
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == ADDR_CAUSE) |=> (rdata_o == $past(cause));
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("cause read data wrong");

  // status keeps every event even beside a clearing write
  property p_stat_set;
    @(posedge clk_i) disable iff (rst_i)
    (evt != 6'h00) |=> ((irq_stat & $past(evt)) == $past(evt));
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("event lost from status");

  // the software enable only moves on a write to the cause register
  property p_swdt_keep;
    @(posedge clk_i) disable iff (rst_i)
    !wr_cause |=> $stable(sw_wdt);
  endproperty
  a_swdt_keep: assert property (p_swdt_keep)
    else $error("watchdog enable changed without write");

  // unimplemented bits of the cause register always read zero
  property p_unimpl_zero;
    @(posedge clk_i) disable iff (rst_i)
    (cause & ~CAUSE_WMASK) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented cause bit set");

endmodule

// File: bench/reset_cause_flags_test.sv
// self-checking bench for the reset cause flag block, integer model.
// assumes rcf_pkg and the logic files are compiled ahead of it.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module reset_cause_flags_test;
  import rcf_pkg::*;
  logic              clk_i;
  logic              rst_i;
  logic              wr_i;
  logic              rd_i;
  logic              force_on;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic [DATA_W-1:0] rdata_o;
  logic [5:0]        ev;
  logic              wd_en;
  logic              irq;
  int                errors;
  int                tests_run;
  int                cyc;
  int                cause;
  int                stat;
  int                mask;
  int                pos[6] = '{BIT_WATCHDOG_TIMEOUT_FLAG, BIT_SWRST, BIT_EXT, BIT_CFGMM,
                                BIT_ILLOP, BIT_TRAP};

  rcf_top u_rcf_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .master_clear_pin_i(ev[2]), .sw_reset_instr_i(ev[1]),
    .watchdog_expired_i(ev[0]), .trap_conflict_i(ev[5]),
    .illegal_op_i(ev[4]), .config_mismatch_i(ev[3]),
    .cfg_watchdog_force_on_i(force_on), .watchdog_enable_o(wd_en),
    .irq_o(irq));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // hang guard, well above the roughly 180 cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one write cycle; the model follows the register map
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a == ADDR_CAUSE) cause = d & CAUSE_WMASK;
    if (a == ADDR_IRQ_STAT) stat = stat & ~int'(d);
    if (a == ADDR_IRQ_MASK) mask = d & 16'h003F;
  endtask

  // read data are only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input int e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 `CHK(rdata_o, 16'(e))
  endtask

  // one-cycle event pulse on source k
  task automatic pulse(input int k);
    @(posedge clk_i);
    ev <= 6'(1 << k);
    @(posedge clk_i);
    ev <= 6'h00;
    cause = cause | (1 << pos[k]);
    stat  = stat | (1 << k);
  endtask

  // level outputs against the model, after the edge settles
  task automatic chk_out;
    #1 `CHK(wd_en, force_on | cause[BIT_SWDT])
    `CHK(irq, |(stat & mask & 6'h3F))
  endtask

  // main sequence
  initial begin
    void'($urandom(62514));
    {rst_i, wr_i, rd_i, force_on} = 4'h8;
    {addr_i, wdata_i, ev, errors, tests_run, cyc} = '0;
    {cause, stat, mask} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 5; a++) rd(4'(a), 0);
    for (int k = 0; k < 6; k++) begin
      pulse(k);
      rd(ADDR_CAUSE, cause);
      rd(ADDR_IRQ_STAT, stat);
    end
    wr(ADDR_IRQ_MASK, 16'h0021);
    chk_out();
    wr(ADDR_IRQ_STAT, 16'h003F);
    chk_out();
    wr(4'h7, 16'hFFFF);
    rd(ADDR_CAUSE, cause);
    wr(ADDR_CAUSE, 16'h0000);
    rd(ADDR_CAUSE, 0);
    wr(ADDR_CAUSE, 16'hFFFF);
    rd(ADDR_CAUSE, CAUSE_WMASK);
    rd(ADDR_IRQ_STAT, 0);
    chk_out();
    // trap event beside a clearing write: the event must win
    @(posedge clk_i);
    ev      <= 6'h20;
    addr_i  <= ADDR_CAUSE;
    wdata_i <= 16'h0000;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    {ev, wr_i} <= '0;
    cause = 1 << BIT_TRAP;
    stat  = stat | 6'h20;
    rd(ADDR_CAUSE, cause);
    rd(ADDR_IRQ_STAT, stat);
    chk_out();
    @(posedge clk_i) force_on <= 1'b1;
    wr(ADDR_CAUSE, 16'h0000);
    chk_out();
    rd(ADDR_WDT_STATE, 1);
    // random cause words and force levels
    repeat (20) begin
      @(posedge clk_i) force_on <= 1'($urandom);
      wr(ADDR_CAUSE, 16'($urandom));
      rd(ADDR_CAUSE, cause);
      chk_out();
    end
    give_verdict();
  end
endmodule
